/* hbtm_assertions.sv */
`timescale 1ns/1ps
module hbtm_assertions
	import hbtm_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic             core_clk,
	input wire logic             srst,
	input wire logic             controllerSelect,
	input wire logic [CFG_W-1:0] transceiverConfig,
	input wire logic             hostIoSupply,
	input wire hbtm_spi_t        linkRx,
	input wire logic             alertOut,
	input wire hbtm_spi_t        hostSpiOut,
	input wire hbtm_spi_t        hostSpiOe,
	input wire logic             hostPociOe,
	input wire logic             isoDriveEn
);
	logic [63:0] sh;
	logic [6:0]  nb;
	logic [31:0] lowCnt;
	logic        sckQ, csQ, fEnd, mon, hdrOk;
	assign fEnd  = linkRx.csN && !csQ;
	assign mon   = hostSpiOe == 3'h7;
	assign hdrOk = fEnd && nb == 7'h40 && sh[63:32] == HB_HEADER;
	// Raw pins; bit times are long enough to agree with the synced view
	always_ff @(posedge core_clk) begin
		sckQ <= linkRx.sck;
		csQ  <= linkRx.csN;
		if (srst || fEnd) begin
			nb <= '0;
		end else if (!linkRx.csN && linkRx.sck && !sckQ) begin
			sh <= {sh[62:0], linkRx.data};
			nb <= nb + 7'h01;
		end
	end
	always_ff @(posedge core_clk) begin
		if (srst || alertOut || !mon) begin
			lowCnt <= '0;
		end else begin
			lowCnt <= lowCnt + 32'h1;
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	a_activate_alert: assert property (
		$fell(controllerSelect) && transceiverConfig == CFG_PD20K |-> ##[1:5] alertOut)
		else $error("alert not raised on activation");
	a_exit_release: assert property (
		$rose(controllerSelect) |-> ##[1:6] (!alertOut && isoDriveEn))
		else $error("alert or drivers wrong after exit");
	a_iso_quiet: assert property (mon |-> !isoDriveEn && !hostPociOe)
		else $error("drivers active while monitoring");
	a_alert_in_mon: assert property (alertOut |-> mon)
		else $error("alert outside monitoring");
	a_cfg_gate: assert property ((transceiverConfig != CFG_PD20K) [*5] |-> !alertOut)
		else $error("alert with monitor disabled");
	a_pass_clears: assert property (
		hdrOk && sh[31:0] == HB_PASS_DATA && mon |-> ##[1:6] !alertOut)
		else $error("pass did not clear alert");
	a_fail_raises: assert property (
		hdrOk && sh[31:0] != HB_PASS_DATA && mon |-> ##[1:6] alertOut)
		else $error("fail did not raise alert");
	a_low_holds: assert property ($fell(alertOut) |-> !alertOut [*8])
		else $error("alert rose right after clearing");
	a_forward_link: assert property (
		mon && $past(hostSpiOe, 4) == 3'h7 && hostIoSupply && $past(hostIoSupply, 4)
		|-> hostSpiOut == $past(linkRx, 3))
		else $error("link traffic not forwarded");
	a_idle_unpowered: assert property (!hostIoSupply [*5] |-> hostSpiOut == SPI_IDLE)
		else $error("host pins not idle without supply");
	a_timeout_cap: assert property (lowCnt <= 48004 * TICK_CYCLES)
		else $error("timer ran past longest period");
endmodule // hbtm_assertions

bind hbtm_top hbtm_assertions #(.TICK_CYCLES(TICK_CYCLES)) hbtm_assertions_i (
	.core_clk(core_clk), .srst(srst), .controllerSelect(controllerSelect),
	.transceiverConfig(transceiverConfig), .hostIoSupply(hostIoSupply), .linkRx(linkRx),
	.alertOut(alertOut), .hostSpiOut(hostSpiOut), .hostSpiOe(hostSpiOe),
	.hostPociOe(hostPociOe), .isoDriveEn(isoDriveEn)
);

/* hbtm_frame_rx.sv */
`timescale 1ns/1ps
module hbtm_frame_rx
	import hbtm_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire hbtm_spi_t   linkIn,
	output logic             frameValid,
	output hbtm_frame_t      frame
);

	logic                   csPrev_reg;
	logic                   sckPrev_reg;
	logic [BITCNT_W-1:0]    bitCnt_reg;
	logic [HB_HDR_BITS-1:0] shift_reg;
	logic [HB_HDR_BITS-1:0] header_reg;
	logic                   csFall;
	logic                   csRise;
	logic                   sckRise;

	assign csFall  = csPrev_reg & ~linkIn.csN;
	assign csRise  = ~csPrev_reg & linkIn.csN;
	assign sckRise = ~sckPrev_reg & linkIn.sck & ~linkIn.csN;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			csPrev_reg  <= SPI_IDLE.csN;
			sckPrev_reg <= SPI_IDLE.sck;
		end else begin
			csPrev_reg  <= linkIn.csN;
			sckPrev_reg <= linkIn.sck;
		end
	end

	// Bits enter at the low end, so the first bit ends up most significant
	always_ff @(posedge core_clk) begin
		if (srst || csFall) begin
			shift_reg <= '0;
		end else if (sckRise) begin
			shift_reg <= {shift_reg[HB_HDR_BITS-2:0], linkIn.data}; // R21
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			header_reg <= '0;
		end else if (sckRise && bitCnt_reg == BITCNT_W'(HB_HDR_BITS - 1)) begin
			header_reg <= {shift_reg[HB_HDR_BITS-2:0], linkIn.data}; // R14
		end
	end

	// Saturates so an overlong transfer never wraps back to 64
	always_ff @(posedge core_clk) begin
		if (srst || csFall) begin
			bitCnt_reg <= '0;
		end else if (sckRise && bitCnt_reg != BITCNT_MAX) begin
			bitCnt_reg <= bitCnt_reg + BITCNT_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			frameValid <= 1'b0;
			frame      <= '0;
		end else begin
			frameValid <= csRise;
			if (csRise) begin
				frame <= '{header: header_reg, data: shift_reg, bits: bitCnt_reg};
			end
		end
	end

endmodule // hbtm_frame_rx

/* hbtm_link_model.sv */
`timescale 1ns/1ps
module hbtm_link_model
	import hbtm_pkg::*;
(
	input  wire logic core_clk,
	output hbtm_spi_t linkRx
);
	initial linkRx = SPI_IDLE;
	// Released data line toggles so a stale bit never looks valid
	always @(posedge core_clk) begin
		if (linkRx.csN) begin
			linkRx.data <= ~linkRx.data;
		end
	end
	// Sends the top n bits of w; n below 64 makes a short frame
	task automatic send(input logic [63:0] w, input int n);
		@(posedge core_clk);
		linkRx.csN <= 1'b0;
		for (int i = 63; i >= 64 - n; i--) begin
			@(posedge core_clk);
			linkRx.data <= w[i];
			repeat (3) @(posedge core_clk);
			linkRx.sck <= 1'b1;
			repeat (3) @(posedge core_clk);
			linkRx.sck <= 1'b0;
		end
		repeat (3) @(posedge core_clk);
		linkRx.csN <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask
endmodule // hbtm_link_model

/* hbtm_pkg.sv */
package hbtm_pkg;

	// Clock and timer base
	localparam int CLK_MHZ         = 100;
	localparam int TICK_US         = 1000;
	localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;
	localparam int US_PER_MS       = 1000;
	localparam int DIV_W           = 17;
	localparam int TMR_W           = 16;

	// Heartbeat framing
	localparam int          HB_HDR_BITS  = 32;
	localparam int          HB_MSG_BITS  = 64;
	localparam int          BITCNT_W     = 7;
	localparam logic [6:0]  BITCNT_MAX   = 7'h7F;
	localparam logic [31:0] HB_HEADER    = 32'h004347B2;
	localparam logic [31:0] HB_PASS_DATA = 32'h42000394;

	// Pin setting codes
	localparam int         CFG_W         = 3;
	localparam int         RTO_W         = 3;
	localparam logic [2:0] CFG_PD20K     = 3'h2;
	localparam logic [2:0] RTO_SEL_1S5   = 3'h0;
	localparam logic [2:0] RTO_SEL_3S    = 3'h1;
	localparam logic [2:0] RTO_SEL_6S    = 3'h2;
	localparam logic [2:0] RTO_SEL_12S   = 3'h3;
	localparam logic [2:0] RTO_SEL_18S   = 3'h4;
	localparam logic [2:0] RTO_SEL_24S   = 3'h5;
	localparam logic [2:0] RTO_SEL_48S   = 3'h6;

	// Monitor measurement periods and the timeout margin of one half
	localparam int MEAS_MS_1S5 = 1000;
	localparam int MEAS_MS_3S  = 2000;
	localparam int MEAS_MS_6S  = 4000;
	localparam int MEAS_MS_12S = 8000;
	localparam int MEAS_MS_18S = 12000;
	localparam int MEAS_MS_24S = 16000;
	localparam int MEAS_MS_48S = 32000;
	localparam int MARGIN_NUM  = 3;
	localparam int MARGIN_DEN  = 2;

	// Register byte offsets
	localparam logic [7:0] REG_STATUS    = 8'h00;
	localparam logic [7:0] REG_TIMER     = 8'h04;
	localparam logic [7:0] REG_PERIOD    = 8'h08;
	localparam logic [7:0] REG_PASS_CNT  = 8'h0C;
	localparam logic [7:0] REG_FAIL_CNT  = 8'h10;
	localparam logic [7:0] REG_IGN_CNT   = 8'h14;
	localparam logic [7:0] REG_LAST_DATA = 8'h18;
	localparam logic [7:0] REG_LAST_BITS = 8'h1C;
	localparam logic [7:0] REG_TICK_DIV  = 8'h20;
	localparam logic [7:0] REG_CTRL      = 8'h24;
	localparam int         CNT_W         = 16;
	localparam int         CTRL_CLR_BIT  = 0;

	typedef enum {HBTM_OFF, HBTM_MON} hbtm_state_t;

	typedef struct packed {
		logic csN;
		logic sck;
		logic data;
	} hbtm_spi_t;

	typedef struct packed {
		logic [31:0]         header;
		logic [31:0]         data;
		logic [BITCNT_W-1:0] bits;
	} hbtm_frame_t;

	typedef struct packed {
		logic             ctlSel;
		logic             hostSupply;
		hbtm_spi_t        link;
		logic [CFG_W-1:0] cfg;
		logic [RTO_W-1:0] timeout_resistor_sel;
	} hbtm_pins_t;

	typedef struct packed {
		logic [RTO_W-1:0] timeout_resistor_sel;
		logic             cfgEnabled;
		logic             hostSupply;
		logic             ctlSel;
		logic             alert;
		logic             monitoring;
	} hbtm_status_t;

	localparam hbtm_pins_t PINS_RST = '{ctlSel: 1'b1, hostSupply: 1'b0,
		link: '{csN: 1'b1, sck: 1'b0, data: 1'b1}, cfg: 3'h0, timeout_resistor_sel: 3'h0};
	localparam hbtm_spi_t  SPI_IDLE = '{csN: 1'b1, sck: 1'b0, data: 1'b1};

	function automatic logic [TMR_W-1:0] tmo_ticks(input logic [RTO_W-1:0] sel);
		int meas;
		meas = MEAS_MS_1S5;
		case (sel)
			RTO_SEL_3S:  meas = MEAS_MS_3S;
			RTO_SEL_6S:  meas = MEAS_MS_6S;
			RTO_SEL_12S: meas = MEAS_MS_12S;
			RTO_SEL_18S: meas = MEAS_MS_18S;
			RTO_SEL_24S: meas = MEAS_MS_24S;
			RTO_SEL_48S: meas = MEAS_MS_48S;
			default:     meas = MEAS_MS_1S5;
		endcase
		tmo_ticks = TMR_W'((meas * MARGIN_NUM / MARGIN_DEN) * US_PER_MS / TICK_US);
	endfunction

endpackage

/* hbtm_sync.sv */
`timescale 1ns/1ps
module hbtm_sync
	import hbtm_pkg::*;
#(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         core_clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);

	logic [W-1:0] stage1_reg;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			stage1_reg <= RST_VAL;
			syncOut    <= RST_VAL;
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end

endmodule // hbtm_sync

/* hbtm_top.sv */
`timescale 1ns/1ps
// What this block does
// (R01) Monitor runs only while the config pin decodes the 20k pull-down.
// (R02) Host holds select high while talking; configures monitors before pulling it low.
// (R03) Select falling with monitoring enabled drives the alert high at once.
// (R04) After activation the alert stays high until the first pass heartbeat.
// (R05) Whenever the alert drops low the timer restarts from zero.
// (R06) A pass heartbeat before timeout keeps alert low and restarts the timer.
// (R07) A fail heartbeat or an expired timer drives the alert high.
// (R08) Timeout period comes from the resistor select: seven choices, 1.5 to 48 s.
// (R09) Each timeout is half again the matching monitor measurement period.
// (R10) While monitoring with host supply present, link traffic is forwarded to host.
// (R11) Isolated-link output drivers stay off while monitoring; receive only.
// (R12) Select going high drops the alert and ends monitoring.
// (R13) Host restores supplies, raises select, then ends monitor low-power mode.
// (R14) A heartbeat is 64 bits: command with check code, then data with check.
// (R15) Only an exact 32-bit header match makes a heartbeat; others are ignored.
// (R16) Header bytes are 00, 43, 47, B2 in that order.
// (R17) Data 42, 00, 03, 94 is a pass; any other data is a fail.
// (R18) A matched header with length other than 64 bits is an immediate fail.
// (R19) Data part holds 16 bits of count and flags plus 16 check bits.
// (R20) On activation host chip-select, clock and data-out pins drive; data-in floats.
// (R21) Bytes compared in arrival order, most significant bit first.
// (R22) Timer ticks from an internal free-running divider covering the longest period.
module hbtm_top
	import hbtm_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             controllerSelect,
	input  wire logic [CFG_W-1:0] transceiverConfig,
	input  wire logic [RTO_W-1:0] timeoutResistorSel,
	input  wire logic             hostIoSupply,
	input  wire hbtm_spi_t        linkRx,
	output logic                  alertOut,
	output hbtm_spi_t             hostSpiOut,
	output hbtm_spi_t             hostSpiOe,
	output logic                  hostPociOe,
	output logic                  isoDriveEn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr
);

	hbtm_pins_t       pinsRaw;
	hbtm_pins_t       pins;
	logic             frameValid;
	hbtm_frame_t      frame;
	hbtm_state_t      monState_reg;
	logic             ctlSelPrev_reg;
	logic             cfgEnabled;
	logic             activate;
	logic             deactivate;
	logic             monitoring;
	logic             hdrMatch;
	logic             hbPass;
	logic             hbFail;
	logic             hbIgnored;
	logic [DIV_W-1:0] tickDiv_reg;
	logic [DIV_W-1:0] tickCnt_reg;
	logic             tick;
	logic [TMR_W-1:0] timer_reg;
	logic [TMR_W-1:0] period;
	logic             expire;
	logic [CNT_W-1:0] passCnt_reg;
	logic [CNT_W-1:0] failCnt_reg;
	logic [CNT_W-1:0] ignCnt_reg;
	logic [31:0]      lastData_reg;
	logic [BITCNT_W-1:0] lastBits_reg;
	logic             setupPhase;
	logic             wrAccess;
	logic             clrCounters;
	logic [31:0]      rdNext;
	logic             errNext;
	hbtm_status_t     status;

	// Every pin from outside this clock passes two flops
	assign pinsRaw = '{ctlSel: controllerSelect, hostSupply: hostIoSupply, link: linkRx,
		cfg: transceiverConfig, timeout_resistor_sel: timeoutResistorSel};

	hbtm_sync #(
		.W       ($bits(hbtm_pins_t)),
		.RST_VAL (PINS_RST)
	) u_sync (
		.core_clk (core_clk),
		.srst     (srst),
		.asyncIn  (pinsRaw),
		.syncOut  (pins)
	);

	hbtm_frame_rx u_frame_rx (
		.core_clk   (core_clk),
		.srst       (srst),
		.linkIn     (pins.link),
		.frameValid (frameValid),
		.frame      (frame)
	);

	// Activation control
	assign cfgEnabled = (pins.cfg == CFG_PD20K); // R01
	assign activate   = ctlSelPrev_reg & ~pins.ctlSel & cfgEnabled; // R01 R03
	assign deactivate = pins.ctlSel | ~cfgEnabled; // R12 R01
	assign monitoring = (monState_reg == HBTM_MON);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctlSelPrev_reg <= PINS_RST.ctlSel;
		end else begin
			ctlSelPrev_reg <= pins.ctlSel;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			monState_reg <= HBTM_OFF;
		end else begin
			case (monState_reg)
				HBTM_OFF: begin
					if (activate) begin
						monState_reg <= HBTM_MON; // R03
					end
				end
				HBTM_MON: begin
					if (deactivate) begin
						monState_reg <= HBTM_OFF; // R12
					end
				end
				default: monState_reg <= HBTM_OFF;
			endcase
		end
	end

	// Heartbeat classification
	assign hdrMatch  = frameValid && (frame.bits >= BITCNT_W'(HB_HDR_BITS))
		&& (frame.header == HB_HEADER); // R15 R16
	assign hbPass    = hdrMatch && (frame.bits == BITCNT_W'(HB_MSG_BITS))
		&& (frame.data == HB_PASS_DATA); // R17 R19
	assign hbFail    = hdrMatch && !hbPass; // R17 R18
	assign hbIgnored = frameValid && !hdrMatch; // R15

	// Free-running tick of divider+1 cycles; software may trim it to the oscillator
	assign tick = (tickCnt_reg == '0);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			tickCnt_reg <= DIV_W'(TICK_CYCLES - 1);
		end else if (tick) begin
			tickCnt_reg <= tickDiv_reg; // R22
		end else begin
			tickCnt_reg <= tickCnt_reg - DIV_W'(1);
		end
	end

	// Timeout timer and alert
	assign period = tmo_ticks(pins.timeout_resistor_sel); // R08 R09
	assign expire = tick && (timer_reg >= period - TMR_W'(1));

	always_ff @(posedge core_clk) begin
		if (srst) begin
			timer_reg <= '0;
		end else if (!monitoring || alertOut || hbPass) begin
			timer_reg <= '0; // R05 R06
		end else if (tick && !expire) begin
			timer_reg <= timer_reg + TMR_W'(1);
		end
	end

	// Fail outranks pass; only one can occur per frame anyway
	always_ff @(posedge core_clk) begin
		if (srst) begin
			alertOut <= 1'b0;
		end else if (!monitoring) begin
			alertOut <= activate; // R03
		end else if (deactivate) begin
			alertOut <= 1'b0; // R12
		end else if (hbFail) begin
			alertOut <= 1'b1; // R07 R18
		end else if (hbPass) begin
			alertOut <= 1'b0; // R04 R06
		end else if (!alertOut && expire) begin
			alertOut <= 1'b1; // R07
		end
	end

	// Host port direction and forwarding
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hostSpiOe  <= '0;
			hostPociOe <= 1'b1;
		end else if (monitoring || activate) begin
			hostSpiOe  <= '{csN: 1'b1, sck: 1'b1, data: 1'b1}; // R20
			hostPociOe <= 1'b0; // R20
		end else begin
			hostSpiOe  <= '0;
			hostPociOe <= 1'b1;
		end
	end

	// Idle levels shown when the host side is unpowered, avoiding glitches on it
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hostSpiOut <= SPI_IDLE;
		end else if (monitoring && pins.hostSupply) begin
			hostSpiOut <= pins.link; // R10
		end else begin
			hostSpiOut <= SPI_IDLE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			isoDriveEn <= 1'b0;
		end else begin
			isoDriveEn <= !(monitoring || activate); // R11
		end
	end

	// Event counters; a new event wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			passCnt_reg <= '0;
		end else if (monitoring && hbPass) begin
			passCnt_reg <= clrCounters ? CNT_W'(1) : passCnt_reg + CNT_W'(1);
		end else if (clrCounters) begin
			passCnt_reg <= '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			failCnt_reg <= '0;
		end else if (monitoring && hbFail) begin
			failCnt_reg <= clrCounters ? CNT_W'(1) : failCnt_reg + CNT_W'(1);
		end else if (clrCounters) begin
			failCnt_reg <= '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ignCnt_reg <= '0;
		end else if (monitoring && hbIgnored) begin
			ignCnt_reg <= clrCounters ? CNT_W'(1) : ignCnt_reg + CNT_W'(1);
		end else if (clrCounters) begin
			ignCnt_reg <= '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			lastData_reg <= '0;
			lastBits_reg <= '0;
		end else if (hdrMatch) begin
			lastData_reg <= frame.data;
			lastBits_reg <= frame.bits;
		end
	end

	// APB slave: zero wait states, answer in the first access cycle
	assign setupPhase  = psel && !penable;
	assign wrAccess    = psel && penable && pready && pwrite;
	assign clrCounters = wrAccess && (paddr == REG_CTRL) && pwdata[CTRL_CLR_BIT];

	always_ff @(posedge core_clk) begin
		if (srst) begin
			tickDiv_reg <= DIV_W'(TICK_CYCLES - 1);
		end else if (wrAccess && paddr == REG_TICK_DIV) begin
			tickDiv_reg <= pwdata[DIV_W-1:0];
		end
	end

	assign status = '{timeout_resistor_sel: pins.timeout_resistor_sel, cfgEnabled: cfgEnabled, hostSupply: pins.hostSupply,
		ctlSel: pins.ctlSel, alert: alertOut, monitoring: monitoring};

	always_comb begin
		rdNext  = '0;
		errNext = 1'b0;
		if (paddr == REG_STATUS) begin
			rdNext = 32'($unsigned(status));
		end else if (paddr == REG_TIMER) begin
			rdNext = 32'(timer_reg);
		end else if (paddr == REG_PERIOD) begin
			rdNext = 32'(period);
		end else if (paddr == REG_PASS_CNT) begin
			rdNext = 32'(passCnt_reg);
		end else if (paddr == REG_FAIL_CNT) begin
			rdNext = 32'(failCnt_reg);
		end else if (paddr == REG_IGN_CNT) begin
			rdNext = 32'(ignCnt_reg);
		end else if (paddr == REG_LAST_DATA) begin
			rdNext = lastData_reg;
		end else if (paddr == REG_LAST_BITS) begin
			rdNext = 32'(lastBits_reg);
		end else if (paddr == REG_TICK_DIV) begin
			rdNext = 32'(tickDiv_reg);
		end else if (paddr == REG_CTRL) begin
			rdNext = '0;
		end else begin
			errNext = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setupPhase;
			pslverr <= setupPhase && errNext;
			if (setupPhase && !pwrite) begin
				prdata <= rdNext;
			end
		end
	end

endmodule // hbtm_top

/* test_heartbeat_timeout_monitor.sv */
`timescale 1ns/1ps
module test_heartbeat_timeout_monitor
	import hbtm_pkg::*;
();
	localparam int          TK   = 2;
	localparam logic [63:0] PASS = 64'h004347B2_42000394;
	localparam logic [63:0] XHDR = 64'h00000001_00000000;
	typedef struct packed {
		logic [2:0]  sel;
		logic [31:0] meas;
	} hbtm_row_t;
	// Monitor measurement periods in ms
	hbtm_row_t rows [8] = '{'{RTO_SEL_1S5, 32'h3E8}, '{RTO_SEL_3S, 32'h7D0},
		'{RTO_SEL_6S, 32'hFA0}, '{RTO_SEL_12S, 32'h1F40}, '{RTO_SEL_18S, 32'h2EE0},
		'{RTO_SEL_24S, 32'h3E80}, '{RTO_SEL_48S, 32'h7D00}, '{3'h7, 32'h3E8}};
	logic             core_clk, srst, controllerSelect, hostIoSupply, alertOut, er;
	logic             psel, penable, pwrite, pready, pslverr, hostPociOe, isoDriveEn;
	logic [CFG_W-1:0] transceiverConfig;
	logic [RTO_W-1:0] timeoutResistorSel;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, rd;
	hbtm_spi_t        linkRx, hostSpiOut, hostSpiOe;
	int               miscompares, numChecks, n;

	hbtm_top #(.TICK_CYCLES(TK)) hbtm_top_i (
		.core_clk(core_clk), .srst(srst), .controllerSelect(controllerSelect),
		.transceiverConfig(transceiverConfig), .timeoutResistorSel(timeoutResistorSel),
		.hostIoSupply(hostIoSupply), .linkRx(linkRx), .alertOut(alertOut),
		.hostSpiOut(hostSpiOut), .hostSpiOe(hostSpiOe), .hostPociOe(hostPociOe),
		.isoDriveEn(isoDriveEn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
	);
	hbtm_link_model hbtm_link_model_i (.core_clk(core_clk), .linkRx(linkRx));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		numChecks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %0h seen %0h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		chk("pready", 1, 32'(pready));
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic waitAl(input logic v, input int lim);
		n = 0;
		while (alertOut !== v && n < lim) begin
			@(posedge core_clk);
			n++;
		end
		chk("alert", 32'(v), 32'(alertOut));
	endtask
	task automatic td(input string s);
		$display("test %s done", s);
	endtask
	task automatic endSim;
		$display("checks %0d miscompares %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#400000;
		miscompares++;
		endSim();
	end

	initial begin
		{srst, controllerSelect, hostIoSupply} = 3'h7;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		transceiverConfig = CFG_PD20K;
		timeoutResistorSel = RTO_SEL_1S5;
		miscompares = 0;
		numChecks = 0;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("alert rst", 0, 32'(alertOut));
		chk("iso rst", 1, 32'(isoDriveEn));
		chk("oe rst", 32'h1, 32'({hostSpiOe, hostPociOe}));
		td("reset");
		foreach (rows[i]) begin
			timeoutResistorSel <= rows[i].sel;
			repeat (4) @(posedge core_clk);
			apb(0, REG_PERIOD, 0);
			chk("period", rows[i].meas + rows[i].meas / 2, rd);
		end
		timeoutResistorSel <= RTO_SEL_1S5;
		td("periods");
		apb(0, REG_TICK_DIV, 0);
		chk("tick div rst", 32'(TK - 1), rd);
		apb(1, REG_TICK_DIV, 32'h5);
		apb(0, REG_TICK_DIV, 0);
		chk("tick div", 32'h5, rd);
		apb(1, REG_TICK_DIV, 32'(TK - 1));
		apb(1, REG_PERIOD, 32'h1234);
		apb(0, REG_PERIOD, 0);
		chk("period ro", 32'h5DC, rd);
		apb(0, 8'h40, 0);
		chk("unmapped data", 0, rd);
		chk("unmapped err", 1, 32'(er));
		td("registers");
		transceiverConfig <= 3'h0;
		repeat (4) @(posedge core_clk);
		controllerSelect <= 1'b0;
		repeat (10) @(posedge core_clk);
		chk("cfg off alert", 0, 32'(alertOut));
		chk("cfg off iso", 1, 32'(isoDriveEn));
		controllerSelect <= 1'b1;
		transceiverConfig <= CFG_PD20K;
		repeat (6) @(posedge core_clk);
		td("disabled");
		controllerSelect <= 1'b0;
		waitAl(1, 8);
		chk("iso mon", 0, 32'(isoDriveEn));
		chk("oe mon", 32'hE, 32'({hostSpiOe, hostPociOe}));
		apb(0, REG_STATUS, 0);
		chk("status", 32'h1B, rd);
		hbtm_link_model_i.send(PASS ^ XHDR, 64);
		chk("ignored", 1, 32'(alertOut));
		apb(0, REG_IGN_CNT, 0);
		chk("ign cnt", 32'h1, rd);
		hbtm_link_model_i.send(PASS, 64);
		waitAl(0, 8);
		repeat (1000 * TK) @(posedge core_clk);
		chk("before tmo", 0, 32'(alertOut));
		hbtm_link_model_i.send(PASS, 64);
		waitAl(1, 1600 * TK);
		chk("tmo span", 1, 32'(n >= 1500 * TK - 16 && n <= 1500 * TK + 16));
		td("timeout");
		hbtm_link_model_i.send(PASS, 64);
		waitAl(0, 8);
		apb(1, REG_CTRL, 32'h1);
		hostIoSupply <= 1'b0;
		hbtm_link_model_i.send(PASS ^ 64'h1, 64);
		waitAl(1, 8);
		chk("no forward", 32'(SPI_IDLE), 32'(hostSpiOut));
		hostIoSupply <= 1'b1;
		hbtm_link_model_i.send(PASS, 64);
		waitAl(0, 8);
		hbtm_link_model_i.send(PASS, 48);
		waitAl(1, 8);
		apb(0, REG_FAIL_CNT, 0);
		chk("fail cnt", 32'h2, rd);
		apb(0, REG_PASS_CNT, 0);
		chk("pass cnt", 32'h1, rd);
		apb(0, REG_LAST_BITS, 0);
		chk("last bits", 32'h30, rd);
		td("fail");
		controllerSelect <= 1'b1;
		waitAl(0, 8);
		repeat (3) @(posedge core_clk);
		chk("exit pins", 32'h11, 32'({isoDriveEn, hostSpiOe, hostPociOe}));
		hbtm_link_model_i.send(PASS ^ 64'h1, 64);
		chk("off frame", 0, 32'(alertOut));
		td("exit");
		endSim();
	end
endmodule // test_heartbeat_timeout_monitor
